// *** core/hic_pkg.sv ***
package hic_pkg;

  localparam int ADDR_W = 8;

  // Register byte offsets, one 32-bit word each
  localparam logic [7:0] OFF_STAT_LO = 8'h00;
  localparam logic [7:0] OFF_STAT_HI = 8'h04;
  localparam logic [7:0] OFF_TVEC_LO = 8'h08;
  localparam logic [7:0] OFF_TVEC_HI = 8'h0c;
  localparam logic [7:0] OFF_EN_LO = 8'h10;
  localparam logic [7:0] OFF_EN_HI = 8'h14;
  localparam logic [7:0] OFF_EPC_LO = 8'h18;
  localparam logic [7:0] OFF_EPC_HI = 8'h1c;
  localparam logic [7:0] OFF_CAUSE_LO = 8'h20;
  localparam logic [7:0] OFF_CAUSE_HI = 8'h24;
  localparam logic [7:0] OFF_HART = 8'h28;

  // Status word fields
  localparam int ST_SIE = 1;
  localparam int ST_MIE = 3;
  localparam int ST_SPREV_EN = 5;
  localparam int ST_MPREV_EN = 7;
  localparam int ST_SPREV_PRIV = 8;
  localparam int ST_MPREV_PRIV = 11;

  // Enable mask: writable bits 1,3,5,7,9,11
  localparam logic [11:0] EN_MASK = 12'haaa;
  localparam int EN_MSI = 3;
  localparam int EN_MTI = 7;
  localparam int EN_MEI = 11;

  // Interrupt cause codes
  localparam logic [9:0] CODE_MSI = 10'h003;
  localparam logic [9:0] CODE_MTI = 10'h007;
  localparam logic [9:0] CODE_MEI = 10'h00b;

  // Trap vector modes
  localparam logic [1:0] MODE_DIRECT = 2'h0;
  localparam logic [1:0] MODE_VECTOR = 2'h1;

  // Privilege levels
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_M = 2'h3;

  // Hart word field position of the pending vector
  localparam int HART_PEND = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** core/hic_csr.sv ***
// Notes on behaviour
// - Machine interrupt taken with its own mask bit set and either global enable set or privilege below machine.
// - Status holds writable previous-enable bits at 5 and 7.
// - Status holds previous privilege bits at 8 and 12:11, writable.
// - Vector mode comes from vector bits 1:0, only legal values kept.
// - Vector base sits in bits 63:2, only legal values kept.
// - Direct mode sends every trap to the base address.
// - Vectored mode sends interrupts to base plus four times cause code.
// - Vectored base is 64-byte aligned; stored base is forced aligned.
// - External interrupts use cause code 11, so vector to base plus 0x2c.
// - Mask bits 1 and 3 enable software interrupts, readable and writable.
// - Mask bits 5 and 7 enable timer interrupts, readable and writable.
// - Mask bits 9 and 11 enable external interrupts; 63:12 reserved.
// - Interrupt entry saves enable, clears it, saves privilege and pc.
// - Machine return restores privilege, enable and pc from saved copies.
// - Interrupt trap sets cause top bit and interrupt number in low bits.
module hic_csr
  import hic_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_soft,
  input wire logic irq_timer,
  input wire logic irq_ext,
  input wire logic exc_req,
  input wire logic [9:0] exc_code,
  input wire logic machine_return_instr,
  input wire logic [63:0] pc_in,
  output logic redirect,
  output logic [63:0] redirect_pc,
  output logic [1:0] priv_mode
);

  typedef struct packed {
    logic sie;
    logic mie;
    logic supervisor_prev_enable;
    logic machine_prev_enable;
    logic supervisor_prev_privilege;
    logic [1:0] machine_prev_privilege;
    logic [11:0] en;
    logic [1:0] tv_mode;
    logic [61:0] tv_base;
    logic [63:0] epc;
    logic cause_irq;
    logic [9:0] cause_code;
    logic [1:0] priv;
    logic redirect;
    logic [63:0] redirect_pc;
    logic awready;
    logic wready;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } hic_state_s;

  hic_state_s st_q;
  hic_state_s st_d;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic [11:0] pend;
  logic [11:0] pend_en;
  logic int_take;
  logic [9:0] int_code;
  logic [31:0] stat_lo;
  logic [31:0] tvec_lo;

  // Only machine-level sources arrive here; supervisor pending is elsewhere
  always_comb begin
    pend = 12'h000;
    pend[EN_MSI] = irq_soft;
    pend[EN_MTI] = irq_timer;
    pend[EN_MEI] = irq_ext;
  end

  assign pend_en = pend & st_q.en;
  // Lower privilege is always preempted by an enabled machine interrupt
  assign int_take = (|pend_en) && (st_q.mie || st_q.priv != PRIV_M);

  // Fixed priority: external, then software, then timer
  always_comb begin
    if (pend_en[EN_MEI]) begin
      int_code = CODE_MEI;
    end else if (pend_en[EN_MSI]) begin
      int_code = CODE_MSI;
    end else begin
      int_code = CODE_MTI;
    end
  end

  always_comb begin
    stat_lo = 32'h0000_0000;
    stat_lo[ST_SIE] = st_q.sie;
    stat_lo[ST_MIE] = st_q.mie;
    stat_lo[ST_SPREV_EN] = st_q.supervisor_prev_enable;
    stat_lo[ST_MPREV_EN] = st_q.machine_prev_enable;
    stat_lo[ST_SPREV_PRIV] = st_q.supervisor_prev_privilege;
    stat_lo[ST_MPREV_PRIV +: 2] = st_q.machine_prev_privilege;
    tvec_lo = {st_q.tv_base[29:0], st_q.tv_mode};
  end

  always_comb begin
    logic aw_now;
    logic w_now;
    logic do_wr;
    logic [ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [31:0] nw;
    logic [63:0] tv;
    logic [31:0] rd;
    logic hit;
    aw_now = 1'b0;
    w_now = 1'b0;
    do_wr = 1'b0;
    wa = '0;
    wd = 32'h0000_0000;
    ws = 4'h0;
    nw = 32'h0000_0000;
    tv = 64'h0;
    rd = 32'h0000_0000;
    hit = 1'b0;
    st_d = st_q;
    st_d.redirect = 1'b0;

    // Write path: address and data taken in either order
    aw_now = st_q.aw_have || (s_axi_awvalid && st_q.awready);
    w_now = st_q.w_have || (s_axi_wvalid && st_q.wready);
    wa = st_q.aw_have ? st_q.aw_addr : s_axi_awaddr;
    wd = st_q.w_have ? st_q.wdata : s_axi_wdata;
    ws = st_q.w_have ? st_q.wstrb : s_axi_wstrb;
    do_wr = aw_now && w_now && !st_q.bvalid;
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    if (do_wr) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = RESP_OKAY;
      tv = {st_q.tv_base, st_q.tv_mode};
      unique case ({wa[7:2], 2'b00})
        OFF_STAT_LO: begin
          nw = merge(stat_lo, wd, ws);
          st_d.sie = nw[ST_SIE];
          st_d.mie = nw[ST_MIE];
          st_d.supervisor_prev_enable = nw[ST_SPREV_EN];
          st_d.machine_prev_enable = nw[ST_MPREV_EN];
          st_d.supervisor_prev_privilege = nw[ST_SPREV_PRIV];
          st_d.machine_prev_privilege = nw[ST_MPREV_PRIV +: 2];
        end
        OFF_TVEC_LO: begin
          nw = merge(tvec_lo, wd, ws);
          tv[31:2] = nw[31:2];
          // Reserved modes are dropped, the old legal mode stays
          if (nw[1:0] == MODE_DIRECT || nw[1:0] == MODE_VECTOR) begin
            tv[1:0] = nw[1:0];
          end
        end
        OFF_TVEC_HI: begin
          tv[63:32] = merge(tv[63:32], wd, ws);
        end
        OFF_EN_LO: begin
          nw = merge({20'h00000, st_q.en}, wd, ws);
          st_d.en = nw[11:0] & EN_MASK;
        end
        OFF_STAT_HI, OFF_EN_HI, OFF_EPC_LO, OFF_EPC_HI, OFF_CAUSE_LO,
        OFF_CAUSE_HI, OFF_HART: begin
          st_d.bresp = RESP_OKAY;
        end
        default: begin
          st_d.bresp = RESP_SLVERR;
        end
      endcase
      // Keep the vectored table aligned even if mode is set after base
      if (tv[1:0] == MODE_VECTOR) begin
        tv[5:2] = 4'h0;
      end
      st_d.tv_mode = tv[1:0];
      st_d.tv_base = tv[63:2];
    end
    st_d.awready = !st_d.aw_have && !st_d.bvalid;
    st_d.wready = !st_d.w_have && !st_d.bvalid;

    // Read path
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_q.arready) begin
      hit = 1'b1;
      unique case ({s_axi_araddr[7:2], 2'b00})
        OFF_STAT_LO: rd = stat_lo;
        OFF_TVEC_LO: rd = tvec_lo;
        OFF_TVEC_HI: rd = st_q.tv_base[61:30];
        OFF_EN_LO: rd = {20'h00000, st_q.en};
        OFF_EPC_LO: rd = st_q.epc[31:0];
        OFF_EPC_HI: rd = st_q.epc[63:32];
        OFF_CAUSE_LO: rd = {22'h000000, st_q.cause_code};
        OFF_CAUSE_HI: rd = {st_q.cause_irq, 31'h00000000};
        OFF_HART: rd = {16'h0000, pend, 2'b00, st_q.priv};
        OFF_STAT_HI, OFF_EN_HI: rd = 32'h0000_0000;
        default: hit = 1'b0;
      endcase
      st_d.rvalid = 1'b1;
      st_d.rdata = rd;
      st_d.rresp = hit ? RESP_OKAY : RESP_SLVERR;
    end
    st_d.arready = !st_d.rvalid;

    // Hart events override a register write in the same cycle
    if (exc_req) begin
      st_d.machine_prev_enable = st_q.mie;
      st_d.mie = 1'b0;
      st_d.machine_prev_privilege = st_q.priv;
      st_d.priv = PRIV_M;
      st_d.epc = pc_in;
      st_d.cause_irq = 1'b0;
      st_d.cause_code = exc_code;
      st_d.redirect = 1'b1;
      st_d.redirect_pc = {st_q.tv_base, 2'b00};
    end else if (int_take) begin
      st_d.machine_prev_enable = st_q.mie;
      st_d.mie = 1'b0;
      st_d.machine_prev_privilege = st_q.priv;
      st_d.priv = PRIV_M;
      st_d.epc = pc_in;
      st_d.cause_irq = 1'b1;
      st_d.cause_code = int_code;
      st_d.redirect = 1'b1;
      if (st_q.tv_mode == MODE_VECTOR) begin
        st_d.redirect_pc = {st_q.tv_base, 2'b00} +
                           {52'h0, int_code, 2'b00};
      end else begin
        st_d.redirect_pc = {st_q.tv_base, 2'b00};
      end
    end else if (machine_return_instr) begin
      st_d.priv = st_q.machine_prev_privilege;
      st_d.mie = st_q.machine_prev_enable;
      st_d.machine_prev_enable = 1'b1;
      st_d.machine_prev_privilege = PRIV_U;
      st_d.redirect = 1'b1;
      st_d.redirect_pc = st_q.epc;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.priv <= PRIV_M;
      st_q.awready <= 1'b1;
      st_q.wready <= 1'b1;
      st_q.arready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign redirect = st_q.redirect;
  assign redirect_pc = st_q.redirect_pc;
  assign priv_mode = st_q.priv;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic irq_entry;
  assign irq_entry = !exc_req && int_take;

  a_mode_legal: assert property (
    st_q.tv_mode == MODE_DIRECT || st_q.tv_mode == MODE_VECTOR)
    else $error("trap vector mode holds a reserved value");

  logic do_wr_hi_mode;
  assign do_wr_hi_mode = s_axi_awvalid && st_q.awready && s_axi_wvalid &&
                         st_q.wready && s_axi_wstrb[0] &&
                         s_axi_awaddr == OFF_TVEC_LO &&
                         s_axi_wdata[1:0] > MODE_VECTOR;

  a_mode_kept: assert property (
    do_wr_hi_mode |=> st_q.tv_mode == $past(st_q.tv_mode))
    else $error("reserved mode write changed the mode");

  a_en_reserved: assert property (
    (st_q.en & ~EN_MASK) == 12'h000)
    else $error("reserved enable bit set");

  a_take_needs_en: assert property (
    (!exc_req && (pend & st_q.en) == 12'h000) |=> !st_q.cause_irq ||
      st_q.cause_code == $past(st_q.cause_code))
    else $error("interrupt taken without its enable");

  a_entry_saves: assert property (
    irq_entry |=> !st_q.mie &&
      st_q.machine_prev_enable == $past(st_q.mie) &&
      st_q.machine_prev_privilege == $past(st_q.priv) &&
      st_q.epc == $past(pc_in) && st_q.cause_irq)
    else $error("interrupt entry did not save state");

  a_direct_pc: assert property (
    (irq_entry && st_q.tv_mode == MODE_DIRECT) |=>
      st_q.redirect && st_q.redirect_pc == {$past(st_q.tv_base), 2'b00})
    else $error("direct mode target is not the base");

  a_vector_pc: assert property (
    (irq_entry && st_q.tv_mode == MODE_VECTOR) |=>
      st_q.redirect_pc == {$past(st_q.tv_base), 2'b00} +
        {52'h0, st_q.cause_code, 2'b00})
    else $error("vectored target is wrong");

  a_ext_vector: assert property (
    (irq_entry && pend_en[EN_MEI] && st_q.tv_mode == MODE_VECTOR) |=>
      st_q.cause_code == CODE_MEI &&
      st_q.redirect_pc == {$past(st_q.tv_base), 2'b00} + 64'h2c)
    else $error("external interrupt vector is wrong");

  a_return_restore: assert property (
    (machine_return_instr && !exc_req && !int_take) |=>
      st_q.priv == $past(st_q.machine_prev_privilege) &&
      st_q.mie == $past(st_q.machine_prev_enable) &&
      st_q.redirect_pc == $past(st_q.epc))
    else $error("machine return did not restore state");

  a_vec_align: assert property (
    st_q.tv_mode == MODE_VECTOR |-> st_q.tv_base[3:0] == 4'h0)
    else $error("vectored base not 64-byte aligned");

  a_bresp_hold: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid &&
      $stable(s_axi_bresp))
    else $error("write response dropped before taken");

endmodule

// *** tb/hic_hart_model.sv ***
module hic_hart_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic redirect,
  input wire logic [63:0] redirect_pc,
  output logic [63:0] pc_in,
  output logic [63:0] last_pc
);
  timeunit 1ns;
  timeprecision 1ns;

  initial pc_in = 64'h0000_0000_8000_0000;
  initial last_pc = 64'h0;

  // Fetch obeys a redirect at once, so the saved pc is a moving target
  always @(posedge aclk) begin
    last_pc <= pc_in;
    if (!aresetn) begin
      pc_in <= 64'h0000_0000_8000_0000;
    end else if (redirect) begin
      pc_in <= redirect_pc;
    end else begin
      pc_in <= pc_in + 64'h4;
    end
  end
endmodule

// *** tb/tb_hic_csr.sv ***
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("mismatch %s exp %h seen %h", nm, e, g); \
  end \
end

module tb_hic_csr;
  import hic_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } hic_row_s;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [2:0] irq = 3'h0;
  logic exc_req = 1'b0;
  logic [9:0] exc_code = 10'h000;
  logic mach_ret = 1'b0;
  logic [63:0] pc_in;
  logic [63:0] last_pc;
  logic redirect;
  logic [63:0] redirect_pc;
  logic [1:0] priv_mode;
  int err_count = 0;
  int cmp_count = 0;
  int redir_cnt = 0;
  int n0;
  logic [63:0] epc;
  logic [1:0] r;
  logic [31:0] d;
  logic [9:0] codes [3] = '{CODE_MSI, CODE_MTI, CODE_MEI};
  logic [2:0] srcs [3] = '{3'h1, 3'h2, 3'h4};
  hic_row_s rows [9] = '{
    '{OFF_STAT_LO, 32'hffffffff, 32'h000019aa, RESP_OKAY},
    '{OFF_STAT_HI, 32'hffffffff, 32'h00000000, RESP_OKAY},
    '{OFF_EN_LO, 32'hffffffff, 32'h00000aaa, RESP_OKAY},
    '{OFF_EN_HI, 32'hffffffff, 32'h00000000, RESP_OKAY},
    '{OFF_TVEC_LO, 32'h00001003, 32'h00001000, RESP_OKAY},
    '{OFF_TVEC_LO, 32'h0000107d, 32'h00001041, RESP_OKAY},
    '{OFF_TVEC_LO, 32'h00001002, 32'h00001001, RESP_OKAY},
    '{OFF_TVEC_HI, 32'h12345678, 32'h12345678, RESP_OKAY},
    '{8'h30, 32'hffffffff, 32'h00000000, RESP_SLVERR}};

  always #50 aclk = ~aclk;

  // Counted mid-cycle so a read at the next rising edge never races it
  always @(negedge aclk) begin
    if (redirect === 1'b1) redir_cnt++;
  end

  hic_csr u_hic_csr (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_soft(irq[0]),
    .irq_timer(irq[1]), .irq_ext(irq[2]), .exc_req(exc_req),
    .exc_code(exc_code), .machine_return_instr(mach_ret), .pc_in(pc_in),
    .redirect(redirect), .redirect_pc(redirect_pc),
    .priv_mode(priv_mode)
  );

  hic_hart_model u_hic_hart_model (
    .aclk(aclk), .aresetn(aresetn), .redirect(redirect),
    .redirect_pc(redirect_pc), .pc_in(pc_in), .last_pc(last_pc)
  );

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic bump(inout int n);
    n++;
    if (n > 50) begin
      err_count++;
      $display("mismatch wait exp 1 seen 0");
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd,
                    output logic [1:0] rs);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !aw) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      bump(n);
    end
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      bump(n);
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] rdv,
                    output logic [1:0] rs);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      bump(n);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      bump(n);
    end while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wchk(input logic [7:0] a, input logic [31:0] wd);
    logic [1:0] rs;
    wr(a, wd, rs);
    `CHK("bresp", RESP_OKAY, rs)
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] rdv;
    logic [1:0] rs;
    rd(a, rdv, rs);
    `CHK("rdata", e, rdv)
  endtask

  // Leaves the bench just after the edge that saw the pulse
  task automatic wait_redir();
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      bump(n);
    end while (redirect !== 1'b1);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, r);
      `CHK("bresp", rows[i].r, r)
      rd(rows[i].a, d, r);
      `CHK("rresp", rows[i].r, r)
      `CHK("rdata", rows[i].e, d)
    end
    $display("test registers done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(OFF_STAT_LO, 32'h0);
    rchk(OFF_TVEC_LO, 32'h0);
    rchk(OFF_EN_LO, 32'h0);
    rchk(OFF_HART, {30'h0, PRIV_M});
    $display("test reset done");
    wchk(OFF_TVEC_LO, 32'h1001);
    wchk(OFF_EN_LO, 32'h888);
    for (int i = 0; i < 3; i++) begin
      wchk(OFF_STAT_LO, 32'h8);
      irq <= srcs[i];
      wait_redir();
      epc = last_pc;
      `CHK("pc", 64'h1000 + {52'h0, codes[i], 2'b00}, redirect_pc)
      n0 = redir_cnt;
      rchk(OFF_CAUSE_LO, {22'h0, codes[i]});
      rchk(OFF_CAUSE_HI, 32'h8000_0000);
      rchk(OFF_STAT_LO, 32'h1880);
      rchk(OFF_EPC_LO, epc[31:0]);
      `CHK("count", n0, redir_cnt)
      irq <= 3'h0;
      mach_ret <= 1'b1;
      @(posedge aclk);
      mach_ret <= 1'b0;
      wait_redir();
      `CHK("ret pc", epc, redirect_pc)
      rchk(OFF_STAT_LO, 32'h88);
      `CHK("priv", PRIV_M, priv_mode)
    end
    $display("test vectored done");
    wchk(OFF_EN_LO, 32'h080);
    wchk(OFF_STAT_LO, 32'h8);
    irq <= 3'h5;
    n0 = redir_cnt;
    repeat (5) @(posedge aclk);
    `CHK("masked", n0, redir_cnt)
    rchk(OFF_HART, 32'h0000_8083);
    wchk(OFF_STAT_LO, 32'h0);
    wchk(OFF_EN_LO, 32'h888);
    wchk(OFF_TVEC_LO, 32'h1000);
    repeat (5) @(posedge aclk);
    `CHK("global off", n0, redir_cnt)
    irq <= 3'h7;
    wchk(OFF_STAT_LO, 32'h8);
    wait_redir();
    `CHK("direct pc", 64'h1000, redirect_pc)
    irq <= 3'h0;
    rchk(OFF_CAUSE_LO, {22'h0, CODE_MEI});
    $display("test direct done");
    wchk(OFF_TVEC_LO, 32'h1001);
    exc_code <= 10'h002;
    exc_req <= 1'b1;
    @(posedge aclk);
    exc_req <= 1'b0;
    wait_redir();
    `CHK("exc pc", 64'h1000, redirect_pc)
    rchk(OFF_CAUSE_HI, 32'h0);
    $display("test exception done");
    // Return to user level, where an enabled source preempts with mie clear
    wchk(OFF_STAT_LO, 32'h0);
    mach_ret <= 1'b1;
    @(posedge aclk);
    mach_ret <= 1'b0;
    wait_redir();
    `CHK("user priv", PRIV_U, priv_mode)
    rchk(OFF_STAT_LO, 32'h80);
    irq <= 3'h4;
    wait_redir();
    `CHK("user pc", 64'h102c, redirect_pc)
    irq <= 3'h0;
    rchk(OFF_STAT_LO, 32'h0);
    `CHK("entry priv", PRIV_M, priv_mode)
    $display("test user done");
    give_verdict();
  end
endmodule
